// ==== src/usm_serial_engine.sv ====
// Ten-bit frame UART engine with a 16-word transmit FIFO and register port.
// Assumes baud_tick is a one-cycle mclk pulse at sixteen times the bit rate.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "usm_params.svh"

// ----------------------------------------------------------------
// Synchronous FIFO
// ----------------------------------------------------------------
module usm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wptr;
  logic [AW-1:0]    next_rptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    next_wptr  = push ? AW'(wptr + 1'b1) : wptr;
    next_rptr  = pop ? AW'(rptr + 1'b1) : rptr;
    next_count = count;
    if (push && !pop) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (AW+1)'(count - 1'b1);
    end
  end

  // Storage holds no reset; only the pointers and count need one
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
    if (sys_rst) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
  end
endmodule

// ----------------------------------------------------------------
// Serial engine top
// ----------------------------------------------------------------
module usm_serial_engine #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // Register port
  input  wire logic           [1:0] reg_addr,
  input  wire logic           [7:0] reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic                [7:0] reg_rdata,
  // Baud source
  input  wire logic                 baud_tick,
  // Serial line
  input  wire logic                 rxd,
  output logic                      txd
);
  import usm_pkg::*;

  usm_req_s   req;
  usm_frame_s frame;

  // Register state
  logic       receive_done_flag;
  logic       transmit_done_flag;
  logic       multiprocessor_filter_enable;
  logic [7:0] serial_data_buffer;
  logic       received_ninth_bit;
  logic       next_rdone;
  logic       next_tdone;
  logic       next_filter;
  logic [7:0] next_buffer;
  logic       next_ninth;
  logic [7:0] next_rdata;

  // FIFO wires
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_pop;
  logic [7:0] fifo_out_data;

  // Transmit state
  usm_tx_e    tx_state;
  usm_tx_e    next_tx_state;
  logic [3:0] tx_div;
  logic [3:0] next_tx_div;
  logic [8:0] tx_shift;
  logic [8:0] next_tx_shift;
  logic       next_txd;
  logic       tx_roll;
  logic       tx_done_set;

  // Receive state
  usm_rx_e    rx_state;
  usm_rx_e    next_rx_state;
  logic [3:0] rx_div;
  logic [3:0] next_rx_div;
  logic [8:0] rx_shift;
  logic [8:0] next_rx_shift;
  logic [2:0] rx_samp;
  logic [2:0] next_rx_samp;
  logic       rx_first;
  logic       next_rx_first;
  logic       rx_meta;
  logic       rx_sync;
  logic       rx_prev;
  logic       next_rx_prev;
  logic       rx_roll;
  logic       rx_bit;
  logic       rx_load;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  // Writes while full are dropped; software watches the full bit
  usm_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (req.wr && req.addr == `USM_ADDR_DATA),
    .in_ready  (fifo_in_ready),
    .in_data   (req.wdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign tx_roll  = baud_tick && (tx_div == `USM_DIV_LAST);
  assign fifo_pop = (tx_state == USM_TX_IDLE) && fifo_out_valid;

  // Transmit controller; own counter so receive edges never disturb it
  always_comb begin
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_txd      = txd;
    tx_done_set   = 1'b0;
    next_tx_div   = baud_tick ? 4'(tx_div + 1'b1) : tx_div;
    case (tx_state)
      USM_TX_IDLE: begin
        next_txd = 1'b1;
        if (fifo_out_valid) begin
          next_tx_shift = {`USM_TX_MARKER, fifo_out_data};
          next_tx_state = USM_TX_REQ;
        end
      end
      USM_TX_REQ: begin
        if (tx_roll) begin
          next_txd      = 1'b0;
          next_tx_state = USM_TX_START;
        end
      end
      USM_TX_START: begin
        if (tx_roll) begin
          next_txd      = tx_shift[0];
          next_tx_state = USM_TX_DATA;
        end
      end
      USM_TX_DATA: begin
        if (tx_roll) begin
          next_tx_shift = {1'b0, tx_shift[8:1]};
          next_txd      = tx_shift[1];
          if (tx_shift[8:1] == `USM_TX_LASTPAT) begin
            tx_done_set   = 1'b1;
            next_tx_state = USM_TX_IDLE;
          end
        end
      end
      default: begin
        next_tx_state = USM_TX_IDLE;
      end
    endcase
  end

  // Transmit registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_state <= USM_TX_IDLE;
      tx_div   <= `USM_RESET_DIV;
      tx_shift <= '0;
      txd      <= 1'b1;
    end else begin
      tx_state <= next_tx_state;
      tx_div   <= next_tx_div;
      tx_shift <= next_tx_shift;
      txd      <= next_txd;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // Pin synchroniser; first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rxd;
      rx_sync <= rx_meta;
    end
  end

  assign rx_roll = baud_tick && (rx_div == `USM_DIV_LAST);
  // Majority of the three mid-bit samples rejects short glitches
  assign rx_bit  = (rx_samp[0] & rx_samp[1]) | (rx_samp[1] & rx_samp[2]) |
                   (rx_samp[0] & rx_samp[2]);
  assign rx_load = !receive_done_flag &&
                   (!multiprocessor_filter_enable || rx_bit);
  assign frame   = '{data: {rx_shift[0], rx_shift[1], rx_shift[2], rx_shift[3],
                            rx_shift[4], rx_shift[5], rx_shift[6], rx_shift[7]},
                     ninth: rx_bit};

  // Receive controller
  always_comb begin
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_samp  = rx_samp;
    next_rx_first = rx_first;
    next_rx_prev  = baud_tick ? rx_sync : rx_prev;
    next_rx_div   = baud_tick ? 4'(rx_div + 1'b1) : rx_div;
    case (rx_state)
      USM_RX_HUNT: begin
        if (baud_tick && rx_prev && !rx_sync) begin
          next_rx_div   = `USM_RESET_DIV;
          next_rx_shift = `USM_RX_FILL;
          next_rx_first = 1'b1;
          next_rx_state = USM_RX_RECV;
        end
      end
      USM_RX_RECV: begin
        if (baud_tick && rx_div == `USM_SMP_FIRST) begin
          next_rx_samp[0] = rx_sync;
        end
        if (baud_tick && rx_div == `USM_SMP_MID) begin
          next_rx_samp[1] = rx_sync;
        end
        if (baud_tick && rx_div == `USM_SMP_LAST) begin
          next_rx_samp[2] = rx_sync;
        end
        if (rx_roll) begin
          next_rx_first = 1'b0;
          next_rx_shift = {rx_shift[7:0], rx_bit};
          if (rx_first && rx_bit) begin
            next_rx_state = USM_RX_HUNT;
            next_rx_shift = `USM_RX_FILL;
          end else if (!rx_shift[8]) begin
            next_rx_state = USM_RX_HUNT;
          end
        end
      end
      default: begin
        next_rx_state = USM_RX_HUNT;
      end
    endcase
  end

  // Receive registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_state <= USM_RX_HUNT;
      rx_div   <= `USM_RESET_DIV;
      rx_shift <= `USM_RX_FILL;
      rx_samp  <= 3'h7;
      rx_first <= 1'b0;
      rx_prev  <= 1'b1;
    end else begin
      rx_state <= next_rx_state;
      rx_div   <= next_rx_div;
      rx_shift <= next_rx_shift;
      rx_samp  <= next_rx_samp;
      rx_first <= next_rx_first;
      rx_prev  <= next_rx_prev;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Hardware set beats a software clear landing in the same cycle
  always_comb begin
    next_rdone  = receive_done_flag;
    next_tdone  = transmit_done_flag;
    next_filter = multiprocessor_filter_enable;
    next_buffer = serial_data_buffer;
    next_ninth  = received_ninth_bit;
    next_rdata  = `USM_RESET_BYTE;
    if (req.wr && req.addr == `USM_ADDR_CTRL) begin
      next_rdone  = receive_done_flag & req.wdata[`USM_CTRL_RDONE];
      next_tdone  = transmit_done_flag & req.wdata[`USM_CTRL_TDONE];
      next_filter = req.wdata[`USM_CTRL_FILT];
    end
    if (tx_done_set) begin
      next_tdone = 1'b1;
    end
    if (rx_state == USM_RX_RECV && rx_roll && !rx_first && !rx_shift[8]
        && rx_load) begin
      next_buffer = frame.data;
      next_ninth  = frame.ninth;
      next_rdone  = 1'b1;
    end
    if (req.rd) begin
      case (req.addr)
        `USM_ADDR_DATA: next_rdata = serial_data_buffer;
        `USM_ADDR_CTRL: begin
          next_rdata[`USM_CTRL_RDONE] = receive_done_flag;
          next_rdata[`USM_CTRL_TDONE] = transmit_done_flag;
          next_rdata[`USM_CTRL_NINTH] = received_ninth_bit;
          next_rdata[`USM_CTRL_FILT]  = multiprocessor_filter_enable;
          next_rdata[`USM_CTRL_FULL]  = !fifo_in_ready;
          next_rdata[`USM_CTRL_BUSY]  = (tx_state != USM_TX_IDLE) || fifo_out_valid;
        end
        default: next_rdata = `USM_RESET_BYTE;
      endcase
    end
  end

  // Register file and read data
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      receive_done_flag            <= 1'b0;
      transmit_done_flag           <= 1'b0;
      multiprocessor_filter_enable <= 1'b0;
      serial_data_buffer           <= `USM_RESET_BYTE;
      received_ninth_bit           <= 1'b0;
      reg_rdata                    <= `USM_RESET_BYTE;
    end else begin
      receive_done_flag            <= next_rdone;
      transmit_done_flag           <= next_tdone;
      multiprocessor_filter_enable <= next_filter;
      serial_data_buffer           <= next_buffer;
      received_ninth_bit           <= next_ninth;
      reg_rdata                    <= next_rdata;
    end
  end
endmodule

// ==== include/usm_params.svh ====
// Constants of the ten-bit frame serial engine: offsets, fields, resets.
// Assumes a single clock, mclk, and a one-cycle 16x baud tick from a timer.
//
// Behaviour
// - Data buffer write loads marker one at ninth shift position and requests sending.
// - Sending starts just after next divide-by-16 rollover, aligning bits to counter.
// - Start bit first; one bit later shift output drives pin; shift a bit later.
// - Shift right with zero fill; last shift ends sending, sets transmit done.
// - Receiver samples input at sixteen times baud, starts on high-to-low edge.
// - Start edge resets receive divide-by-16 counter and loads 1FFH into shifter.
// - Sample input at counter states seven, eight, nine; majority of three wins.
// - Nonzero first bit resets receiver to edge hunting; else start bit shifts in.
// - Shift in from right; final shift loads only if flag clear and filter passes.
// - Accepted frame puts stop bit in ninth flag, data in buffer, sets done.
// - After final receive shift, always return to hunting for a falling edge.
// - Frame is zero start, eight data bits LSB first, one stop bit.
// - Bit rate comes from the timer overflow tick feeding the divide-by-16 counter.
`ifndef USM_PARAMS_SVH
`define USM_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define USM_ADDR_DATA   2'h0
`define USM_ADDR_CTRL   2'h1

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define USM_CTRL_RDONE  0
`define USM_CTRL_TDONE  1
`define USM_CTRL_NINTH  2
`define USM_CTRL_FILT   3
`define USM_CTRL_FULL   4
`define USM_CTRL_BUSY   5

// ----------------------------------------------------------------
// Counter states and reset values
// ----------------------------------------------------------------
`define USM_DIV_LAST    4'hF
`define USM_SMP_FIRST   4'h7
`define USM_SMP_MID     4'h8
`define USM_SMP_LAST    4'h9
`define USM_RX_FILL     9'h1FF
`define USM_TX_MARKER   1'h1
`define USM_TX_LASTPAT  8'h01
`define USM_RESET_BYTE  8'h00
`define USM_RESET_DIV   4'h0

`endif

// ==== include/usm_pkg.sv ====
// Types shared by the serial engine: states and carriers.
// Assumes usm_params.svh is compiled alongside.
package usm_pkg;

  // Transmit controller states
  typedef enum logic [1:0] {
    USM_TX_IDLE  = 2'b00,
    USM_TX_REQ   = 2'b01,
    USM_TX_START = 2'b10,
    USM_TX_DATA  = 2'b11
  } usm_tx_e;

  // Receive controller states
  typedef enum logic [0:0] {
    USM_RX_HUNT = 1'b0,
    USM_RX_RECV = 1'b1
  } usm_rx_e;

  // Register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } usm_req_s;

  // Accepted frame
  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
  } usm_frame_s;

endpackage

// ==== sim/usm_serial_engine_checker.sv ====
// Checker for the serial engine: register port and txd bit timing.
// Assumes it is bound to usm_serial_engine and sees only its ports.
`timescale 1ns/100ps

// --------
// Checker
// --------
module usm_serial_engine_checker #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // Watched ports
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       baud_tick,
  input wire logic       rxd,
  input wire logic       txd
);
  logic        txd_q;
  logic [15:0] tcnt;
  logic [7:0]  lcnt;
  logic        filt;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Ticks since txd last moved, low ticks, and a filter shadow
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txd_q <= 1'b1;
      tcnt  <= 16'h0000;
      lcnt  <= 8'h00;
      filt  <= 1'b0;
    end else begin
      txd_q <= txd;
      tcnt  <= (txd != txd_q) ? {15'h0, baud_tick} : tcnt + {15'h0, baud_tick};
      lcnt  <= txd ? 8'h00 : lcnt + {7'h0, baud_tick};
      if (reg_wr && reg_addr == 2'h1) begin
        filt <= reg_wdata[3];
      end
    end
  end

  sequence s_ctrl_rd;
    reg_rd && reg_addr == 2'h1;
  endsequence
  // Flag clear, then read-back next cycle, no tick to set them again
  sequence s_flag_clr;
    reg_wr && reg_addr == 2'h1 && reg_wdata[1:0] == 2'h0 && !baud_tick
    ##1 reg_rd && reg_addr == 2'h1 && !baud_tick;
  endsequence

  property p_rdata_idle;
    reg_rdata != 8'h00 |-> $past(reg_rd);
  endproperty
  property p_unmapped;
    reg_rd && reg_addr[1] |=> reg_rdata == 8'h00;
  endproperty
  property p_txd_on_tick;
    $changed(txd) |-> $past(baud_tick) || $past(baud_tick, 2);
  endproperty
  // A shared divider reset by receive would break this grid
  property p_txd_grid;
    txd != txd_q |-> tcnt[3:0] == 4'h0 && tcnt != 16'h0000;
  endproperty
  property p_txd_low;
    lcnt <= 8'h90;
  endproperty
  property p_filt_rb;
    s_ctrl_rd |=> reg_rdata[3] == filt;
  endproperty
  property p_full_busy;
    s_ctrl_rd |=> !reg_rdata[4] || reg_rdata[5];
  endproperty
  property p_flag_clr;
    s_flag_clr |=> reg_rdata[1:0] == 2'h0;
  endproperty

  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_txd_on_tick: assert property (p_txd_on_tick) else $error("txd moved off tick");
  a_txd_grid: assert property (p_txd_grid) else $error("txd off bit grid");
  a_txd_low: assert property (p_txd_low) else $error("txd low too long");
  a_filt_rb: assert property (p_filt_rb) else $error("filter readback");
  a_full_busy: assert property (p_full_busy) else $error("full but not busy");
  a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared");
endmodule

bind usm_serial_engine usm_serial_engine_checker #(
  .FIFO_DEPTH (FIFO_DEPTH)
) usm_serial_engine_checker_inst (
  .mclk      (mclk),
  .sys_rst   (sys_rst),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .baud_tick (baud_tick),
  .rxd       (rxd),
  .txd       (txd)
);

// ==== sim/usm_line_partner.sv ====
// Remote UART on the line: sends frames on rxd, decodes txd.
// Assumes the bench's 16x baud tick; each bit lasts 16 ticks.
`timescale 1ns/100ps

// --------
// Line partner
// --------
module usm_line_partner (
  // Clock and baud tick
  input  wire logic mclk,
  input  wire logic baud_tick,
  // Serial line
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got_q[$];
  logic       got_stop[$];

  // Idle line sits high
  initial rxd = 1'b1;

  task automatic ticks(input int n);
    repeat (n) @(posedge mclk iff baud_tick);
  endtask

  // Short low gives a false start; glt flips one mid-bit tick of each data bit
  task automatic send(input logic [7:0] d, input logic stp, input int low, input logic glt);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    rxd <= 1'b0;
    ticks(low);
    if (low < 16) begin
      rxd <= 1'b1;
      ticks(32);
    end else begin
      for (int i = 1; i < 10; i++) begin
        rxd <= f[i];
        if (glt && i < 9) begin
          // One-tick flip hits a single one of the three samples
          ticks(9);
          rxd <= ~f[i];
          ticks(1);
          rxd <= f[i];
          ticks(6);
        end else begin
          ticks(16);
        end
      end
      rxd <= 1'b1;
      ticks(16);
    end
  endtask

  // Decode txd at mid-bit
  always begin : decode
    logic [7:0] d;
    @(negedge txd);
    ticks(8);
    for (int i = 0; i < 8; i++) begin
      ticks(16);
      d[i] = txd;
    end
    ticks(16);
    got_q.push_back(d);
    got_stop.push_back(txd);
  end
endmodule

// ==== sim/tb.sv ====
// Bench for the serial engine with line partner and bound checker.
// Assumes a 16x baud tick every fourth mclk cycle.
`timescale 1ns/100ps
`include "usm_params.svh"

// --------
// Bench top
// --------
module tb;
  import usm_pkg::*;

  logic       mclk;
  logic       sys_rst;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       baud_tick;
  logic       rxd;
  logic       txd;
  logic [1:0] tdiv;
  int         miscompares;
  int         total_checks;
  int         cycles;

  usm_serial_engine #(
    .FIFO_DEPTH (16)
  ) usm_serial_engine_inst (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .baud_tick (baud_tick),
    .rxd       (rxd),
    .txd       (txd)
  );

  usm_line_partner usm_line_partner_inst (
    .mclk      (mclk),
    .baud_tick (baud_tick),
    .txd       (txd),
    .rxd       (rxd)
  );

  always #50 mclk = ~mclk;

  // Fast baud tick keeps frames short
  always @(posedge mclk) begin
    tdiv      <= tdiv + 2'h1;
    baud_tick <= (tdiv == 2'h3);
  end

  // Hang guard, well above the run's length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask

  // Ctrl write with read-back in the very next cycle
  task automatic clr(input logic [7:0] d, input logic [7:0] e);
    @(posedge mclk);
    reg_addr  <= `USM_ADDR_CTRL;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge mclk);
    reg_rd    <= 1'b0;
    #1;
    chk("ctrl clr", e, reg_rdata);
  endtask

  // One frame seen by the partner, bounded wait
  task automatic tx_got(input logic [7:0] e);
    int k;
    for (k = 0; k < 2000 && usm_line_partner_inst.got_q.size() == 0; k++) begin
      @(posedge mclk);
    end
    if (usm_line_partner_inst.got_q.size() == 0) begin
      chk("tx frame", 8'h01, 8'h00);
    end else begin
      chk("tx byte", e, usm_line_partner_inst.got_q.pop_front());
      chk("tx stop", 8'h01, {7'h0, usm_line_partner_inst.got_stop.pop_front()});
    end
  endtask

  task automatic t_regs();
    rchk("data", `USM_ADDR_DATA, 8'h00);
    rchk("ctrl", `USM_ADDR_CTRL, 8'h00);
    wr(2'h3, 8'hFF);
    rchk("unmapped", 2'h2, 8'h00);
    rchk("ctrl", `USM_ADDR_CTRL, 8'h00);
  endtask

  task automatic t_tx_one();
    wr(`USM_ADDR_DATA, 8'hA5);
    tx_got(8'hA5);
    rchk("ctrl", `USM_ADDR_CTRL, 8'h02);
    clr(8'h00, 8'h00);
  endtask

  // Fill the queue past full, then drain it all
  task automatic t_burst();
    for (int i = 0; i < 18; i++) begin
      wr(`USM_ADDR_DATA, 8'h10 + 8'(i));
    end
    rchk("ctrl full", `USM_ADDR_CTRL, 8'h30);
    for (int i = 0; i < 17; i++) begin
      tx_got(8'h10 + 8'(i));
    end
    repeat (800) @(posedge mclk);
    chk("extra", 8'h00, 8'(usm_line_partner_inst.got_q.size()));
    rchk("ctrl", `USM_ADDR_CTRL, 8'h02);
    clr(8'h00, 8'h00);
  endtask

  task automatic t_rx();
    usm_line_partner_inst.send(8'h3C, 1'b1, 16, 1'b1);
    rchk("ctrl", `USM_ADDR_CTRL, 8'h05);
    rchk("data", `USM_ADDR_DATA, 8'h3C);
    usm_line_partner_inst.send(8'h55, 1'b1, 16, 1'b0);
    rchk("data", `USM_ADDR_DATA, 8'h3C);
    clr(8'h08, 8'h0C);
    usm_line_partner_inst.send(8'h81, 1'b0, 16, 1'b0);
    rchk("ctrl", `USM_ADDR_CTRL, 8'h0C);
    usm_line_partner_inst.send(8'h7E, 1'b1, 16, 1'b0);
    rchk("ctrl", `USM_ADDR_CTRL, 8'h0D);
    rchk("data", `USM_ADDR_DATA, 8'h7E);
    clr(8'h00, 8'h04);
    usm_line_partner_inst.send(8'h00, 1'b1, 4, 1'b0);
    usm_line_partner_inst.send(8'hC3, 1'b0, 16, 1'b0);
    rchk("ctrl", `USM_ADDR_CTRL, 8'h01);
    rchk("data", `USM_ADDR_DATA, 8'hC3);
    clr(8'h00, 8'h00);
  endtask

  // Both directions at once
  task automatic t_both();
    fork
      wr(`USM_ADDR_DATA, 8'h6B);
      usm_line_partner_inst.send(8'hE7, 1'b1, 16, 1'b0);
    join
    tx_got(8'h6B);
    rchk("data", `USM_ADDR_DATA, 8'hE7);
    rchk("ctrl", `USM_ADDR_CTRL, 8'h07);
  endtask

  initial begin
    mclk         = 1'b0;
    sys_rst      = 1'b1;
    reg_addr     = 2'h0;
    reg_wdata    = 8'h00;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    baud_tick    = 1'b0;
    tdiv         = 2'h0;
    miscompares  = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_tx_one();
    t_burst();
    t_rx();
    t_both();
    conclude();
  end
endmodule
